// ---- verilog/atc_map.svh ----
// Behaviour
// - pin select bit swaps trigger pin immediately
// - type codes: fall, rise, centre, end
// - centre/end triggers only when centre-aligned
// - enable 0: only software start begins conversion
// - enable 1: software or selected external trigger
// - triggers ignored while start bit reads 1
// - power-on bit switches converter off/on
// - compare rising to 1 with brake enable: brake, stop run
// - outputs stay stopped until run set again
// - polarity 0: result>=threshold; 1: result<threshold
// - comparator enable bit disables/enables comparator
// - compare result read-only, refreshed per conversion
// - delay is 9 bits, bit 8 in compare control
// - external trigger waits delay count before starting
// - source codes: channel 0, 2, 4, pin
// - start bit high during conversion, cleared at end
// - done flag blocks starts until software clears
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// register offsets on the byte bus
`define ATC_TRIG_CTRL_ADDR 8'hE1
`define ATC_COMP_CTRL_ADDR 8'hE2
`define ATC_DLY_LOW_ADDR   8'hE3

// reset values
`define ATC_TRIG_CTRL_RST  8'h00
`define ATC_COMP_CTRL_RST  8'h00
`define ATC_DLY_LOW_RST    8'h00

// trigger control field positions
`define ATC_PIN_SEL_BIT    6
`define ATC_TYPE_HI        3
`define ATC_TYPE_LO        2
`define ATC_EXT_EN_BIT     1
`define ATC_POWER_BIT      0
`define ATC_TRIG_WMASK     8'h4F

// compare control field positions
`define ATC_BRAKE_EN_BIT   7
`define ATC_POLARITY_BIT   6
`define ATC_CMP_EN_BIT     5
`define ATC_CMP_OUT_BIT    4
`define ATC_DLY_HI_BIT     0
`define ATC_COMP_WMASK     8'hE1

// widths
`define ATC_DLY_W          9
`define ATC_RESULT_W       12

`endif

// ---- verilog/atc_pkg.sv ----
package atc_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ATC_IDLE    = 2'b00,
    ATC_DELAY   = 2'b01,
    ATC_CONVERT = 2'b10
  } atc_state_t;

  // external trigger condition
  typedef enum logic [1:0] {
    ATC_FALL   = 2'b00,
    ATC_RISE   = 2'b01,
    ATC_CENTRE = 2'b10,
    ATC_END    = 2'b11
  } atc_trig_type_t;

  // external trigger origin
  typedef enum logic [1:0] {
    ATC_SRC_CH0 = 2'b00,
    ATC_SRC_CH2 = 2'b01,
    ATC_SRC_CH4 = 2'b10,
    ATC_SRC_PIN = 2'b11
  } atc_trig_src_t;

endpackage : atc_pkg

// ---- verilog/atc_ctrl.sv ----
`timescale 1ns/10ps
`include "atc_map.svh"

module atc_ctrl #(
  parameter int RESULT_W = `ATC_RESULT_W       // conversion result width
) (
  input  wire logic                i_clk,          // system clock
  input  wire logic                i_nrst,         // async reset, low
  input  wire logic [7:0]          i_sfr_addr,     // register address
  input  wire logic [7:0]          i_sfr_wdata,    // register write data
  input  wire logic                i_sfr_wr,       // register write strobe
  output logic      [7:0]          o_sfr_rdata,    // register read data
  input  wire logic [1:0]          i_ext_trigger_source, // origin code
  input  wire logic                i_start_write,  // software writes 1
  input  wire logic                i_done_clear,   // software clears flag
  output logic                     o_conversion_start, // busy bit
  output logic                     o_conversion_done_flag, // done flag
  output logic                     o_converter_power_on, // analog on
  output logic                     o_convert_go,   // begin pulse
  input  wire logic                i_convert_done, // conversion end pulse
  input  wire logic [RESULT_W-1:0] i_conversion_result, // result
  input  wire logic [RESULT_W-1:0] i_compare_threshold, // threshold
  input  wire logic                i_ext_pin_a,    // trigger pin choice 0
  input  wire logic                i_ext_pin_b,    // trigger pin choice 1
  input  wire logic                i_wave_ch0,     // waveform channel 0
  input  wire logic                i_wave_ch2,     // waveform channel 2
  input  wire logic                i_wave_ch4,     // waveform channel 4
  input  wire logic                i_wave_centre_aligned, // centre type
  input  wire logic                i_wave_centre_pt, // period centre pulse
  input  wire logic                i_wave_end_pt,  // period end pulse
  input  wire logic                i_waveform_run_set, // software run set
  output logic                     o_fault_brake,  // brake to waveform
  output logic                     o_waveform_run_clear // run clear pulse
);

  // software-visible register bits
  logic [7:0]            trig_ctrl;        // trigger control
  logic [7:0]            next_trig_ctrl;
  logic [7:0]            comp_ctrl;        // compare control, rw bits
  logic [7:0]            next_comp_ctrl;
  logic [7:0]            dly_low;          // delay low byte
  logic [7:0]            next_dly_low;
  logic [7:0]            next_rdata;       // read mux result

  // sequencer state
  atc_pkg::atc_state_t   state;            // current state
  atc_pkg::atc_state_t   next_state;
  logic [`ATC_DLY_W-1:0] dly_cnt;          // delay down counter
  logic [`ATC_DLY_W-1:0] next_dly_cnt;
  logic                  start_bit;        // busy bit
  logic                  next_start_bit;
  logic                  done_flag;        // done flag
  logic                  next_done_flag;
  logic                  go;               // begin pulse
  logic                  next_go;

  // trigger detection
  logic                  src_level;        // selected source level
  logic                  src_prev;         // last sampled level
  logic                  ext_hit;          // external condition met
  logic                  ext_ok;           // external trigger accepted
  logic                  sw_ok;            // software start accepted

  // comparator and brake
  logic                  cmp_out;          // compare result bit
  logic                  next_cmp_out;
  logic                  brake;            // fault brake held
  logic                  next_brake;
  logic                  run_clr;          // run clear pulse
  logic                  next_run_clr;
  logic                  cmp_raw;          // live comparison

  // field views
  logic                  pin_sel;
  logic                  ext_en;
  atc_pkg::atc_trig_type_t trig_type;
  atc_pkg::atc_trig_src_t  trig_src;
  logic [`ATC_DLY_W-1:0] dly_val;

  assign pin_sel   = trig_ctrl[`ATC_PIN_SEL_BIT];
  assign ext_en    = trig_ctrl[`ATC_EXT_EN_BIT];
  assign trig_type = atc_pkg::atc_trig_type_t'(
                       trig_ctrl[`ATC_TYPE_HI:`ATC_TYPE_LO]);
  assign trig_src  = atc_pkg::atc_trig_src_t'(i_ext_trigger_source);
  assign dly_val   = {comp_ctrl[`ATC_DLY_HI_BIT], dly_low};

  // register writes
  always_comb begin
    next_trig_ctrl = trig_ctrl;
    next_comp_ctrl = comp_ctrl;
    next_dly_low   = dly_low;
    if (i_sfr_wr) begin
      unique case (i_sfr_addr)
        `ATC_TRIG_CTRL_ADDR: begin
          next_trig_ctrl = i_sfr_wdata & `ATC_TRIG_WMASK;
        end
        `ATC_COMP_CTRL_ADDR: begin
          // compare result bit is never written by software
          next_comp_ctrl = i_sfr_wdata & `ATC_COMP_WMASK;
        end
        `ATC_DLY_LOW_ADDR: begin
          next_dly_low = i_sfr_wdata;
        end
        default: begin
          // other addresses belong elsewhere
          next_trig_ctrl = trig_ctrl;
        end
      endcase
    end
  end

  // read mux, one cycle latency
  always_comb begin
    unique case (i_sfr_addr)
      `ATC_TRIG_CTRL_ADDR: begin
        next_rdata = trig_ctrl;
      end
      `ATC_COMP_CTRL_ADDR: begin
        next_rdata = comp_ctrl;
        next_rdata[`ATC_CMP_OUT_BIT] = cmp_out;
      end
      `ATC_DLY_LOW_ADDR: begin
        next_rdata = dly_low;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // register file flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trig_ctrl   <= `ATC_TRIG_CTRL_RST;
      comp_ctrl   <= `ATC_COMP_CTRL_RST;
      dly_low     <= `ATC_DLY_LOW_RST;
      o_sfr_rdata <= 8'h00;
      o_converter_power_on <= 1'b0;
    end else begin
      trig_ctrl   <= next_trig_ctrl;
      comp_ctrl   <= next_comp_ctrl;
      dly_low     <= next_dly_low;
      o_sfr_rdata <= next_rdata;
      o_converter_power_on <= next_trig_ctrl[`ATC_POWER_BIT];
    end
  end

  // trigger source selection
  always_comb begin
    unique case (trig_src)
      atc_pkg::ATC_SRC_CH0: src_level = i_wave_ch0;
      atc_pkg::ATC_SRC_CH2: src_level = i_wave_ch2;
      atc_pkg::ATC_SRC_CH4: src_level = i_wave_ch4;
      atc_pkg::ATC_SRC_PIN: src_level = pin_sel ? i_ext_pin_b
                                                  : i_ext_pin_a;
    endcase
  end

  // trigger condition
  always_comb begin
    unique case (trig_type)
      atc_pkg::ATC_FALL:   ext_hit = src_prev & ~src_level;
      atc_pkg::ATC_RISE:   ext_hit = ~src_prev & src_level;
      atc_pkg::ATC_CENTRE: ext_hit = i_wave_centre_aligned &
                                     i_wave_centre_pt;
      atc_pkg::ATC_END:    ext_hit = i_wave_centre_aligned &
                                     i_wave_end_pt;
    endcase
  end

  assign ext_ok = ext_en & ext_hit & ~start_bit & ~done_flag;
  assign sw_ok  = i_start_write & ~start_bit & ~done_flag;

  // previous source level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  // conversion sequencer
  always_comb begin
    next_state     = state;
    next_dly_cnt   = dly_cnt;
    next_start_bit = start_bit;
    next_go        = 1'b0;
    next_done_flag = done_flag;
    unique case (state)
      atc_pkg::ATC_IDLE: begin
        if (sw_ok) begin
          // software start begins at once
          next_state     = atc_pkg::ATC_CONVERT;
          next_start_bit = 1'b1;
          next_go        = 1'b1;
        end else if (ext_ok) begin
          if (dly_val == '0) begin
            next_state     = atc_pkg::ATC_CONVERT;
            next_start_bit = 1'b1;
            next_go        = 1'b1;
          end else begin
            next_state   = atc_pkg::ATC_DELAY;
            next_dly_cnt = dly_val;
          end
        end
      end
      atc_pkg::ATC_DELAY: begin
        if (sw_ok || dly_cnt == `ATC_DLY_W'(1)) begin
          next_state     = atc_pkg::ATC_CONVERT;
          next_start_bit = 1'b1;
          next_go        = 1'b1;
          next_dly_cnt   = '0;
        end else begin
          next_dly_cnt = dly_cnt - `ATC_DLY_W'(1);
        end
      end
      atc_pkg::ATC_CONVERT: begin
        if (i_convert_done) begin
          next_state     = atc_pkg::ATC_IDLE;
          next_start_bit = 1'b0;
        end
      end
      default: begin
        // illegal code returns to idle
        next_state     = atc_pkg::ATC_IDLE;
        next_start_bit = 1'b0;
      end
    endcase
    if (i_done_clear) begin
      next_done_flag = 1'b0;
    end
    if (state == atc_pkg::ATC_CONVERT && i_convert_done) begin
      next_done_flag = 1'b1;
    end
  end

  // sequencer flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= atc_pkg::ATC_IDLE;
      dly_cnt   <= '0;
      start_bit <= 1'b0;
      done_flag <= 1'b0;
      go        <= 1'b0;
    end else begin
      state     <= next_state;
      dly_cnt   <= next_dly_cnt;
      start_bit <= next_start_bit;
      done_flag <= next_done_flag;
      go        <= next_go;
    end
  end

  assign o_conversion_start     = start_bit;
  assign o_conversion_done_flag = done_flag;
  assign o_convert_go           = go;

  assign cmp_raw = comp_ctrl[`ATC_POLARITY_BIT]
                 ? (i_conversion_result <  i_compare_threshold)
                 : (i_conversion_result >= i_compare_threshold);

  // comparator and brake
  always_comb begin
    next_cmp_out = cmp_out;
    next_brake   = brake;
    next_run_clr = 1'b0;
    if (!comp_ctrl[`ATC_CMP_EN_BIT]) begin
      next_cmp_out = 1'b0;
    end else if (state == atc_pkg::ATC_CONVERT && i_convert_done) begin
      next_cmp_out = cmp_raw;
    end
    if (i_waveform_run_set) begin
      next_brake = 1'b0;
    end
    if (comp_ctrl[`ATC_BRAKE_EN_BIT] && next_cmp_out && !cmp_out) begin
      next_brake   = 1'b1;
      next_run_clr = 1'b1;
    end
  end

  // comparator flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_out <= 1'b0;
      brake   <= 1'b0;
      run_clr <= 1'b0;
    end else begin
      cmp_out <= next_cmp_out;
      brake   <= next_brake;
      run_clr <= next_run_clr;
    end
  end

  assign o_fault_brake        = brake;
  assign o_waveform_run_clear = run_clr;

endmodule : atc_ctrl

// ---- testbench/atc_ctrl_props.sv ----
`timescale 1ns/10ps
module atc_ctrl_props (
  input wire logic       i_clk,                  // system clock
  input wire logic       i_nrst,                 // reset, low
  input wire logic [7:0] i_sfr_addr,             // register address
  input wire logic [7:0] i_sfr_wdata,            // write data
  input wire logic       i_sfr_wr,               // write strobe
  input wire logic       i_start_write,          // software start
  input wire logic       i_done_clear,           // flag clear
  input wire logic       i_convert_done,         // conversion end
  input wire logic       i_waveform_run_set,     // run set
  input wire logic       o_conversion_start,     // busy bit
  input wire logic       o_conversion_done_flag, // done flag
  input wire logic       o_converter_power_on,   // power
  input wire logic       o_convert_go,           // begin pulse
  input wire logic       o_fault_brake,          // brake
  input wire logic       o_waveform_run_clear    // run clear
);
  // all checks on the system clock, off in reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_sw_start_go:
    assert property (i_start_write && !o_conversion_start &&
      !o_conversion_done_flag |=> o_convert_go && o_conversion_start)
    else $error("software start not answered");
  a_go_busy:
    assert property (o_convert_go |-> o_conversion_start)
    else $error("begin pulse without busy");
  a_end_clears_busy:
    assert property (o_conversion_start && i_convert_done |=>
      !o_conversion_start && o_conversion_done_flag)
    else $error("conversion end not seen");
  a_busy_drops_go:
    assert property (o_conversion_start |=> !o_convert_go)
    else $error("trigger taken while busy");
  a_done_blocks_go:
    assert property (o_conversion_done_flag |=> !o_convert_go)
    else $error("start while done flag set");
  a_done_holds:
    assert property (o_conversion_done_flag && !i_done_clear |=>
      o_conversion_done_flag)
    else $error("done flag lost");
  a_power_write:
    assert property (i_sfr_wr && i_sfr_addr == 8'hE1 |=>
      o_converter_power_on == $past(i_sfr_wdata[0]))
    else $error("power bit wrong");
  a_brake_run_clear:
    assert property ($rose(o_fault_brake) |-> o_waveform_run_clear ##1
      !o_waveform_run_clear)
    else $error("brake without run clear");
  a_brake_holds:
    assert property (o_fault_brake && !i_waveform_run_set |=> o_fault_brake)
    else $error("brake released early");
  a_brake_release:
    assert property (o_fault_brake && i_waveform_run_set && !i_convert_done
      |=> !o_fault_brake)
    else $error("brake not released");

  // main scenarios reached
  c_go: cover property (o_convert_go);
  c_brake: cover property ($rose(o_fault_brake));
  c_clear: cover property (o_conversion_done_flag ##1 !o_conversion_done_flag);
endmodule : atc_ctrl_props

bind atc_ctrl atc_ctrl_props i_atc_ctrl_props (
  .i_clk, .i_nrst, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_start_write,
  .i_done_clear, .i_convert_done, .i_waveform_run_set, .o_conversion_start,
  .o_conversion_done_flag, .o_converter_power_on, .o_convert_go,
  .o_fault_brake, .o_waveform_run_clear
);

// ---- testbench/atc_wave_model.sv ----
`timescale 1ns/10ps
module atc_wave_model (
  input  wire logic i_clk,         // system clock
  input  wire logic i_nrst,        // reset, low
  input  wire logic i_run_set,     // software sets run
  input  wire logic i_run_clear,   // hardware clears run
  input  wire logic i_fault_brake, // brake request
  output logic      o_ch0,         // channel 0 level
  output logic      o_ch2,         // channel 2 level
  output logic      o_ch4,         // channel 4 level
  output logic      o_centre_pt,   // period centre pulse
  output logic      o_end_pt       // period end pulse
);
  logic [3:0] cnt; // period counter
  logic       run; // run bit
  // run cleared by the run clear pulse, set by software
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 4'h0;
      run <= 1'h0;
    end else begin
      run <= i_run_set | (run & ~i_run_clear);
      cnt <= run ? cnt + 4'h1 : 4'h0;
    end
  end
  // brake data is low on every channel
  assign o_ch0 = run & ~i_fault_brake & ~cnt[3];
  assign o_ch2 = run & ~i_fault_brake & cnt[2];
  assign o_ch4 = run & ~i_fault_brake & cnt[1];
  assign o_centre_pt = run & (cnt == 4'h7);
  assign o_end_pt = run & (cnt == 4'hF);
endmodule : atc_wave_model

// ---- testbench/test_adc_trigger_compare_control.sv ----
`timescale 1ns/10ps
module test_adc_trigger_compare_control;
  logic        i_clk = 0, i_nrst = 0;           // clock, reset
  logic [7:0]  addr = 0, wdat = 0, rdat;        // register bus
  logic        wr = 0, sw = 0, clr = 0, cdone = 0, rset = 0;
  logic [1:0]  src = 0, ty;                     // origin, type
  logic [11:0] res = 0, thr = 0, r;             // result, threshold
  logic        pa = 0, pb = 0, cal = 0, pol, en; // pins, modes
  logic        xb = 0;                          // expected run clear
  logic [7:0]  sd = 8'h56;                      // lfsr state
  logic        busy, done, pwr, go, brk, rclr, c0, c2, c4, cp, ep;
  int          bad_count = 0, n_compared = 0, n, d;

  always #2 i_clk = ~i_clk;

  atc_ctrl i_atc_ctrl (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sfr_addr(addr),
    .i_sfr_wdata(wdat), .i_sfr_wr(wr), .o_sfr_rdata(rdat),
    .i_ext_trigger_source(src), .i_start_write(sw), .i_done_clear(clr),
    .o_conversion_start(busy), .o_conversion_done_flag(done),
    .o_converter_power_on(pwr), .o_convert_go(go), .i_convert_done(cdone),
    .i_conversion_result(res), .i_compare_threshold(thr),
    .i_ext_pin_a(pa), .i_ext_pin_b(pb), .i_wave_ch0(c0), .i_wave_ch2(c2),
    .i_wave_ch4(c4), .i_wave_centre_aligned(cal), .i_wave_centre_pt(cp),
    .i_wave_end_pt(ep), .i_waveform_run_set(rset), .o_fault_brake(brk),
    .o_waveform_run_clear(rclr));
  atc_wave_model i_atc_wave_model (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_run_set(rset), .i_run_clear(rclr),
    .i_fault_brake(brk), .o_ch0(c0), .o_ch2(c2), .o_ch4(c4),
    .o_centre_pt(cp), .o_end_pt(ep));

  // pseudo random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // expected comparator output
  function automatic logic cmpx(input logic p, e, input logic [11:0] a, b);
    return e & (p ? a < b : a >= b);
  endfunction : cmpx
  task automatic chk(input string nm, input logic [11:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // wait k edges, then step just past the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, v);
    addr = a;
    wdat = v;
    wr = 1;
    cyc(1);
    wr = 0;
    // one idle edge so the next strobe is a fresh pulse
    cyc(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, e);
    addr = a;
    cyc(1);
    chk("rdata", e, rdat);
  endtask : rreg
  // bounded wait for a begin pulse
  task automatic wait_go(input logic e);
    n = 0;
    while (go !== 1'h1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk("go", e, go);
    if (e && go !== 1'h1) results();
  endtask : wait_go
  task automatic swgo();
    sw = 1;
    cyc(1);
    sw = 0;
    chk("go", 1, go);
    chk("busy", 1, busy);
  endtask : swgo
  // converter side: pins toggle while busy, then end
  task automatic fin(input logic [11:0] v);
    pa = ~pa;
    pb = ~pb;
    cyc(1);
    pa = ~pa;
    pb = ~pb;
    cyc(2);
    res = v;
    cdone = 1;
    cyc(1);
    cdone = 0;
    chk("busy", 0, busy);
    chk("done", 1, done);
    chk("run clear", xb, rclr);
    sw = 1;
    cyc(1);
    sw = 0;
    chk("go", 0, go);
    wreg(8'hE1, 8'h01);
    clr = 1;
    cyc(1);
    clr = 0;
    chk("done", 0, done);
  endtask : fin

  initial begin
    cyc(12);
    i_nrst = 1;
    rset = 1;
    cyc(1);
    rset = 0;
    // reset values, masks and an unmapped place
    for (int i = 0; i < 4; i++) rreg(8'hE1 + i[7:0], 8'h00);
    wreg(8'hE1, 8'hFF);
    chk("power", 1, pwr);
    rreg(8'hE1, 8'h4F);
    wreg(8'hE2, 8'hFF);
    rreg(8'hE2, 8'hE1);
    wreg(8'hE3, sd);
    rreg(8'hE3, sd);
    wreg(8'hE4, 8'hFF);
    rreg(8'hE4, 8'h00);
    wreg(8'hE2, 8'h00);
    wreg(8'hE3, 8'h00);
    wreg(8'hE1, 8'h00);
    chk("power", 0, pwr);
    wreg(8'hE1, 8'h01);
    // external pin ignored while external start is off
    src = 2'h3;
    pa = 1;
    cyc(2);
    pa = 0;
    wait_go(0);
    // comparator, both polarities, equal values first
    for (int i = 0; i < 8; i++) begin
      sd = lfsr(sd);
      r = {sd, sd[7:4]};
      thr = i < 2 ? r : {sd[3:0], lfsr(sd)};
      pol = i < 2 ? i[0] : sd[0];
      en = i < 2 | sd[1];
      wreg(8'hE2, {1'h0, pol, en, 5'h00});
      swgo();
      fin(r);
      rreg(8'hE2, {1'h0, pol, en, cmpx(pol, en, r, thr), 4'h0});
    end
    // pin select, edge types, delay 0, random and 511
    for (int k = 0; k < 4; k++) begin
      sd = lfsr(sd);
      d = k == 3 ? 511 : k == 0 ? 0 : sd;
      wreg(8'hE3, d[7:0]);
      wreg(8'hE2, {7'h00, d[8]});
      pa = ~k[0];
      pb = ~k[0];
      wreg(8'hE1, {1'h0, k[1], 3'h0, k[0], 2'h3});
      if (k[1]) pa = k[0];
      else pb = k[0];
      wait_go(0);
      if (k[1]) pb = k[0];
      else pa = k[0];
      wait_go(1);
      chk("delay", d + 1, n);
      fin(12'h000);
    end
    // channel sources, then centre and end points
    wreg(8'hE3, 8'h00);
    wreg(8'hE2, 8'h00);
    for (int k = 0; k < 7; k++) begin
      src = k < 3 ? k[1:0] : 2'h0;
      cal = k[0];
      ty = k < 3 ? 2'h1 : {1'h1, k > 4};
      wreg(8'hE1, {4'h0, ty, 2'h3});
      wait_go(k < 3 | k[0]);
      if (go === 1'h1) fin(12'h000);
    end
    // compare brake, threshold boundary
    wreg(8'hE2, 8'hA0);
    thr = 12'h800;
    swgo();
    fin(12'h7FF);
    chk("brake", 0, brk);
    swgo();
    xb = 1;
    fin(12'h800);
    xb = 0;
    chk("brake", 1, brk);
    chk("channel", 0, c0);
    rset = 1;
    cyc(1);
    rset = 0;
    chk("brake", 0, brk);
    chk("channel", 1, c0);
    results();
  end
endmodule : test_adc_trigger_compare_control
